/* common/clock_config_select_pkg.sv */
/*
 * Constants shared by the clock configuration decoder: register map,
 * field positions, reset values and the codes of every selector.
 * Assumes a 32-bit APB register bus and a single 100 MHz clock.
 */
// What this block does
// RULE1 - secondary pin source by two-bit code
// RULE2 - code 11 uses unlock pin config
// RULE3 - hybrid mode ratio picked by ratio index
// RULE4 - synthesizer mode ratio index equals active set
// RULE5 - manual source bit picks static or dynamic
// RULE6 - four stored 32-bit ratios
// RULE7 - config 0: push-pull, high when unlocked
// RULE8 - config 1: open drain, low when unlocked
// RULE9 - clock sources ignore unlock pin config
// RULE10 - reference divider 4, 2, 1; 11 reserved
// RULE11 - bit 0: outputs low while unlocked
// RULE12 - bit 1: outputs always enabled
// RULE13 - hybrid format bit: 20.12 or 12.20
// RULE14 - synthesizer mode always uses 12.20
// RULE15 - codes 000/001/010 make output disables
// RULE16 - code 011: pin enables ratio shift
// RULE17 - code 100: pin forces manual source
// RULE18 - code 110: pin overrides source bit
// RULE19 - code 111: pin forces source 10
// RULE20 - disable pin low enables, high disables
// RULE21 - ratio shift only while pin high
// RULE22 - override pin high dynamic, low static
// RULE23 - two mode pins select configuration set
// RULE24 - reserved code gives pin no function
package clock_config_select_pkg;

	localparam int          RATIO_W          = 32;
	localparam int          NUM_SETS         = 4;
	localparam int          ADDR_W           = 8;
	localparam int          MODAL_W          = 7;
	localparam int          GLOBAL_W         = 8;

	// register byte addresses
	localparam logic [7:0]  OFS_RATIO_BASE   = 8'h00;
	localparam logic [7:0]  OFS_MODAL_BASE   = 8'h10;
	localparam logic [7:0]  OFS_GLOBAL       = 8'h20;
	localparam logic [7:0]  OFS_STATUS       = 8'h24;
	localparam logic [7:0]  OFS_ARRAY_MASK   = 8'hF3;

	// modal set fields
	localparam int          MODAL_SHIFT_LSB  = 0;
	localparam int          MODAL_AUX_LSB    = 2;
	localparam int          MODAL_HYB_LSB    = 4;
	localparam int          MODAL_FRAC_BIT   = 6;

	// global fields
	localparam int          GLB_UNLOCK_BIT   = 0;
	localparam int          GLB_DIV_LSB      = 1;
	localparam int          GLB_OOU_BIT      = 3;
	localparam int          GLB_FMT_BIT      = 4;
	localparam int          GLB_SPF_LSB      = 5;

	// status fields
	localparam int          ST_SET_LSB       = 0;
	localparam int          ST_LOCK_BIT      = 2;
	localparam int          ST_DYN_BIT       = 3;
	localparam int          ST_AUX_LSB       = 4;
	localparam int          ST_PRI_EN_BIT    = 6;
	localparam int          ST_SEC_EN_BIT    = 7;
	localparam int          ST_FMT_BIT       = 8;
	localparam int          ST_SHIFT_BIT     = 9;

	// values after reset; ratio 1.0 in 12.20 form
	localparam logic [31:0] RATIO_RST        = 32'h0010_0000;
	localparam logic [6:0]  MODAL_RST        = 7'h00;
	localparam logic [7:0]  GLOBAL_RST       = 8'h04;

	// secondary output source codes
	localparam logic [1:0]  AUX_TIMING_REF   = 2'b00;
	localparam logic [1:0]  AUX_FREQ_REF     = 2'b01;
	localparam logic [1:0]  AUX_PRIMARY      = 2'b10;
	localparam logic [1:0]  AUX_LOCK_IND     = 2'b11;

	// reference divider codes
	localparam logic [1:0]  DIV_BY4          = 2'b00;
	localparam logic [1:0]  DIV_BY2          = 2'b01;
	localparam logic [1:0]  DIV_BY1          = 2'b10;

	// special pin function codes
	localparam logic [2:0]  SPF_DIS_PRIMARY  = 3'b000;
	localparam logic [2:0]  SPF_DIS_SECOND   = 3'b001;
	localparam logic [2:0]  SPF_DIS_BOTH     = 3'b010;
	localparam logic [2:0]  SPF_SHIFT_EN     = 3'b011;
	localparam logic [2:0]  SPF_FORCE_MANUAL = 3'b100;
	localparam logic [2:0]  SPF_RESERVED     = 3'b101;
	localparam logic [2:0]  SPF_SRC_OVERRIDE = 3'b110;
	localparam logic [2:0]  SPF_FORCE_AUX    = 3'b111;

endpackage

/* rtl/clock_config_select.sv */
/*
 * Configuration decoder of a fractional-N clock synthesizer: holds the
 * four ratios, four modal sets and the global parameters, and turns them
 * plus the mode pins into routing, gating and ratio selection.
 * Assumes all inputs, clock sources included, are synchronous to mclk_i,
 * and an APB master with 32-bit data.
 */
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

module clock_config_select
	import clock_config_select_pkg::*;
(
	input  wire logic                mclk_i,
	input  wire logic                arst_n_i,
	input  wire logic                clk_en_i,
	input  wire logic [ADDR_W-1:0]   paddr_i,
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [31:0]         pwdata_i,
	input  wire logic [3:0]          pstrb_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	input  wire logic [1:0]          mode_pins_i,
	input  wire logic                special_mode_pin_i,
	input  wire logic                pll_locked_i,
	input  wire logic                auto_switch_en_i,
	input  wire logic                auto_dynamic_sel_i,
	input  wire logic                timing_reference_clock_i,
	input  wire logic                freq_reference_clock_i,
	input  wire logic                pll_clock_i,
	output logic                     primary_clk_o,
	output logic                     secondary_out_o,
	output logic                     secondary_oe_n_o,
	output logic                     ref_div_clk_o,
	output logic                     fractional_source_sel_o,
	output logic      [RATIO_W-1:0]  active_ratio_o,
	output logic                     ratio_format_12_20_o,
	output logic                     ratio_shift_en_o,
	output logic      [1:0]          ratio_shift_select_o,
	output logic      [RATIO_W-1:0]  effective_ratio_o
);

	////////////////////////////////////////////////////////////////////////
	// stored configuration

	logic [RATIO_W-1:0]   ratio_ff      [NUM_SETS];
	logic [RATIO_W-1:0]   nxt_ratio     [NUM_SETS];
	logic [MODAL_W-1:0]   modal_ff      [NUM_SETS];
	logic [MODAL_W-1:0]   nxt_modal     [NUM_SETS];
	logic [GLOBAL_W-1:0]  global_ff;
	logic [GLOBAL_W-1:0]  nxt_global;

	logic                 wr_take;
	logic                 rd_setup;
	logic [1:0]           acc_idx;
	logic                 hit_ratio;
	logic                 hit_modal;
	logic                 hit_global;
	logic                 hit_status;

	// byte lanes of a write, merged over an old word
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	assign acc_idx    = paddr_i[3:2];
	assign hit_ratio  = (paddr_i & OFS_ARRAY_MASK) == OFS_RATIO_BASE;
	assign hit_modal  = (paddr_i & OFS_ARRAY_MASK) == OFS_MODAL_BASE;
	assign hit_global = paddr_i == OFS_GLOBAL;
	assign hit_status = paddr_i == OFS_STATUS;
	// pready is held high from the first enabled clock after reset, so the access phase always completes here
	assign wr_take    = psel_i & penable_i & pwrite_i & pready_o;
	assign rd_setup   = psel_i & ~penable_i;

	always_comb begin
		nxt_ratio  = ratio_ff;
		nxt_modal  = modal_ff;
		nxt_global = global_ff;
		if (wr_take) begin
			if (hit_ratio) begin
				nxt_ratio[acc_idx] = merge_lanes(ratio_ff[acc_idx], pwdata_i, pstrb_i); // see RULE6
			end
			if (hit_modal && pstrb_i[0]) begin
				nxt_modal[acc_idx] = pwdata_i[MODAL_W-1:0];
			end
			if (hit_global && pstrb_i[0]) begin
				nxt_global = pwdata_i[GLOBAL_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NUM_SETS; i++) begin
				ratio_ff[i] <= RATIO_RST;
				modal_ff[i] <= MODAL_RST;
			end
			global_ff <= GLOBAL_RST;
		end else if (clk_en_i) begin
			ratio_ff  <= nxt_ratio;
			modal_ff  <= nxt_modal;
			global_ff <= nxt_global;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field decode of the active set

	logic [1:0]           set_sel;
	logic [MODAL_W-1:0]   modal_act;
	logic [1:0]           shift_sel;
	logic [1:0]           aux_code;
	logic [1:0]           hyb_idx;
	logic                 frac_bit;
	logic                 unlock_cfg;
	logic [1:0]           div_code;
	logic                 oou_en;
	logic                 fmt_bit;
	logic [2:0]           spf;
	logic                 pin;

	assign set_sel    = mode_pins_i; // see RULE23
	assign modal_act  = modal_ff[set_sel];
	assign shift_sel  = modal_act[MODAL_SHIFT_LSB +: 2];
	assign aux_code   = modal_act[MODAL_AUX_LSB +: 2];
	assign hyb_idx    = modal_act[MODAL_HYB_LSB +: 2];
	assign frac_bit   = modal_act[MODAL_FRAC_BIT];
	assign unlock_cfg = global_ff[GLB_UNLOCK_BIT];
	assign div_code   = global_ff[GLB_DIV_LSB +: 2];
	assign oou_en     = global_ff[GLB_OOU_BIT];
	assign fmt_bit    = global_ff[GLB_FMT_BIT];
	assign spf        = global_ff[GLB_SPF_LSB +: 3];
	assign pin        = special_mode_pin_i;

	////////////////////////////////////////////////////////////////////////
	// special pin mapping and ratio selection

	logic                 dis_primary;
	logic                 dis_secondary;
	logic                 shift_en;
	logic                 auto_active;
	logic                 manual_dyn;
	logic                 dyn_sel;
	logic [1:0]           ratio_idx;
	logic [RATIO_W-1:0]   ratio_sel;
	logic                 fmt_12_20;
	logic [1:0]           aux_eff;
	logic                 clk_gate;

	always_comb begin
		dis_primary   = 1'b0;
		dis_secondary = 1'b0;
		shift_en      = 1'b0;
		auto_active   = auto_switch_en_i;
		manual_dyn    = frac_bit;
		aux_eff       = aux_code;
		case (spf)
			SPF_DIS_PRIMARY: begin
				dis_primary = pin; // see RULE15 see RULE20
			end
			SPF_DIS_SECOND: begin
				dis_secondary = pin; // see RULE15 see RULE20
			end
			SPF_DIS_BOTH: begin
				dis_primary   = pin; // see RULE15 see RULE20
				dis_secondary = pin;
			end
			SPF_SHIFT_EN: begin
				shift_en = pin; // see RULE16 see RULE21
			end
			SPF_FORCE_MANUAL: begin
				auto_active = auto_switch_en_i & ~pin; // see RULE17
			end
			SPF_SRC_OVERRIDE: begin
				manual_dyn = pin; // see RULE18 see RULE22
			end
			SPF_FORCE_AUX: begin
				if (pin) begin
					aux_eff = AUX_PRIMARY; // see RULE19
				end
			end
			default: begin
				// reserved code: the pin has no function at all
				dis_primary = 1'b0; // see RULE24
			end
		endcase
		// the source bit, or its override, only counts without auto switching
		dyn_sel   = auto_active ? auto_dynamic_sel_i : manual_dyn; // see RULE5
		ratio_idx = dyn_sel ? hyb_idx : set_sel; // see RULE3 see RULE4
		ratio_sel = ratio_ff[ratio_idx];
		fmt_12_20 = dyn_sel ? fmt_bit : 1'b1; // see RULE13 see RULE14
		clk_gate  = pll_locked_i | oou_en; // see RULE11 see RULE12
	end

	////////////////////////////////////////////////////////////////////////
	// timing reference divider

	logic                 ref_prev_ff;
	logic                 nxt_ref_prev;
	logic                 ref_half_ff;
	logic                 nxt_ref_half;
	logic                 ref_div_ff;
	logic                 nxt_ref_div;
	logic                 ref_rise;

	assign ref_rise = timing_reference_clock_i & ~ref_prev_ff;

	always_comb begin
		nxt_ref_prev = timing_reference_clock_i;
		nxt_ref_half = ref_half_ff;
		nxt_ref_div  = ref_div_ff;
		case (div_code)
			DIV_BY4: begin
				if (ref_rise) begin
					nxt_ref_half = ~ref_half_ff;
					if (ref_half_ff) begin
						nxt_ref_div = ~ref_div_ff; // see RULE10
					end
				end
			end
			DIV_BY2: begin
				if (ref_rise) begin
					nxt_ref_div = ~ref_div_ff; // see RULE10
				end
			end
			DIV_BY1: begin
				nxt_ref_div = timing_reference_clock_i; // see RULE10
			end
			default: begin
				// reserved setting: hold the divided clock low
				nxt_ref_div = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_prev_ff <= 1'b0;
			ref_half_ff <= 1'b0;
			ref_div_ff  <= 1'b0;
		end else if (clk_en_i) begin
			ref_prev_ff <= nxt_ref_prev;
			ref_half_ff <= nxt_ref_half;
			ref_div_ff  <= nxt_ref_div;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output routing

	logic                 nxt_primary;
	logic                 nxt_sec_out;
	logic                 nxt_sec_oe_n;
	logic [RATIO_W-1:0]   nxt_eff_ratio;

	always_comb begin
		nxt_primary  = pll_clock_i & clk_gate & ~dis_primary;
		nxt_sec_oe_n = 1'b0;
		case (aux_eff)
			AUX_TIMING_REF: begin
				nxt_sec_out = timing_reference_clock_i; // see RULE1 see RULE9
			end
			AUX_FREQ_REF: begin
				nxt_sec_out = freq_reference_clock_i; // see RULE1 see RULE9
			end
			AUX_PRIMARY: begin
				nxt_sec_out = pll_clock_i & clk_gate; // see RULE1 see RULE9
			end
			AUX_LOCK_IND: begin
				if (unlock_cfg) begin // see RULE2
					nxt_sec_out  = 1'b0; // see RULE8
					nxt_sec_oe_n = pll_locked_i;
				end else begin
					nxt_sec_out  = ~pll_locked_i; // see RULE7
				end
			end
			default: begin
				nxt_sec_out = 1'b0;
			end
		endcase
		// a disabled secondary pin is driven low, whatever its source
		if (dis_secondary) begin
			nxt_sec_out  = 1'b0; // see RULE15 see RULE20
			nxt_sec_oe_n = 1'b0;
		end
		// shift right by one to four places
		if (shift_en) begin
			nxt_eff_ratio = ratio_sel >> ({1'b0, shift_sel} + 3'd1); // see RULE21
		end else begin
			nxt_eff_ratio = ratio_sel;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			primary_clk_o           <= 1'b0;
			secondary_out_o         <= 1'b0;
			secondary_oe_n_o        <= 1'b0;
			fractional_source_sel_o <= 1'b0;
			active_ratio_o          <= RATIO_RST;
			ratio_format_12_20_o    <= 1'b1;
			ratio_shift_en_o        <= 1'b0;
			ratio_shift_select_o    <= 2'b00;
			effective_ratio_o       <= RATIO_RST;
		end else if (clk_en_i) begin
			primary_clk_o           <= nxt_primary;
			secondary_out_o         <= nxt_sec_out;
			secondary_oe_n_o        <= nxt_sec_oe_n;
			fractional_source_sel_o <= dyn_sel;
			active_ratio_o          <= ratio_sel;
			ratio_format_12_20_o    <= fmt_12_20;
			ratio_shift_en_o        <= shift_en;
			ratio_shift_select_o    <= shift_sel;
			effective_ratio_o       <= nxt_eff_ratio;
		end
	end

	assign ref_div_clk_o = ref_div_ff;

	////////////////////////////////////////////////////////////////////////
	// apb answer, prepared during the setup cycle

	logic [31:0]          nxt_prdata;
	logic                 nxt_pslverr;
	logic [31:0]          status_word;

	always_comb begin
		status_word                       = 32'h0000_0000;
		status_word[ST_SET_LSB +: 2]      = set_sel;
		status_word[ST_LOCK_BIT]          = pll_locked_i;
		status_word[ST_DYN_BIT]           = dyn_sel;
		status_word[ST_AUX_LSB +: 2]      = aux_eff;
		status_word[ST_PRI_EN_BIT]        = clk_gate & ~dis_primary;
		status_word[ST_SEC_EN_BIT]        = ~dis_secondary;
		status_word[ST_FMT_BIT]           = fmt_12_20;
		status_word[ST_SHIFT_BIT]         = shift_en;
		nxt_prdata  = prdata_o;
		nxt_pslverr = pslverr_o;
		if (rd_setup) begin
			nxt_prdata  = 32'h0000_0000;
			nxt_pslverr = 1'b0;
			if (hit_ratio) begin
				nxt_prdata = ratio_ff[acc_idx];
			end else if (hit_modal) begin
				nxt_prdata[MODAL_W-1:0] = modal_ff[acc_idx];
			end else if (hit_global) begin
				nxt_prdata[GLOBAL_W-1:0] = global_ff;
			end else if (hit_status) begin
				// status is read only; a write there is refused
				nxt_prdata  = status_word;
				nxt_pslverr = pwrite_i;
			end else begin
				nxt_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
			pready_o  <= 1'b0;
		end else if (clk_en_i) begin
			prdata_o  <= nxt_prdata;
			pslverr_o <= nxt_pslverr;
			pready_o  <= 1'b1;
		end
	end

endmodule // clock_config_select

/* tb/clock_config_select_sva.sv */
/*
 * Port-level checker for clock_config_select: APB answers, ratio shift,
 * ratio format, lock indicator drive and primary clock gating.
 * Assumes clk_en_i only drops while clock and lock inputs rest, and is
 * bound from the foot of this file.
 */
`timescale 1ns/100ps

module clock_config_select_sva
	import clock_config_select_pkg::*;
(
	input wire logic                mclk_i,
	input wire logic                arst_n_i,
	input wire logic                clk_en_i,
	input wire logic [ADDR_W-1:0]   paddr_i,
	input wire logic                psel_i,
	input wire logic                penable_i,
	input wire logic                pwrite_i,
	input wire logic                pready_o,
	input wire logic                pslverr_o,
	input wire logic                pll_locked_i,
	input wire logic                pll_clock_i,
	input wire logic                primary_clk_o,
	input wire logic                secondary_out_o,
	input wire logic                secondary_oe_n_o,
	input wire logic                fractional_source_sel_o,
	input wire logic [RATIO_W-1:0]  active_ratio_o,
	input wire logic                ratio_format_12_20_o,
	input wire logic                ratio_shift_en_o,
	input wire logic [1:0]          ratio_shift_select_o,
	input wire logic [RATIO_W-1:0]  effective_ratio_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	////////////////////////////////////////////////////////////////////////
	// the release edge itself still sees reset on the sampled inputs
	property p_ready; arst_n_i && clk_en_i |=> pready_o; endproperty
	a_ready: assert property (p_ready) else $error("pready low after reset");

	property p_unmapped;
		psel_i && penable_i && pready_o && (paddr_i > OFS_STATUS || paddr_i[1:0] != 2'b00) |-> pslverr_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");

	property p_status_ro;
		psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFS_STATUS |-> pslverr_o;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write accepted");

	property p_shift_off; !ratio_shift_en_o |-> effective_ratio_o == active_ratio_o; endproperty
	a_shift_off: assert property (p_shift_off) else $error("ratio changed without shift");

	property p_shift_on;
		ratio_shift_en_o |-> effective_ratio_o == (active_ratio_o >> ({1'b0, ratio_shift_select_o} + 3'd1));
	endproperty
	a_shift_on: assert property (p_shift_on) else $error("shifted ratio wrong");

	property p_static_fmt; !fractional_source_sel_o |-> ratio_format_12_20_o; endproperty
	a_static_fmt: assert property (p_static_fmt) else $error("static ratio not 12.20");

	// released pin must not be driven and only happens while locked
	property p_od_release; secondary_oe_n_o |-> !secondary_out_o && $past(pll_locked_i); endproperty
	a_od_release: assert property (p_od_release) else $error("bad open drain release");

	property p_pri_gate; primary_clk_o |-> $past(pll_clock_i); endproperty
	a_pri_gate: assert property (p_pri_gate) else $error("primary high without pll clock");

	c_shift: cover property (ratio_shift_en_o);
	c_od: cover property (secondary_oe_n_o);
	c_dyn: cover property (fractional_source_sel_o ##1 !fractional_source_sel_o);
endmodule // clock_config_select_sva

bind clock_config_select clock_config_select_sva clock_config_select_sva_inst (.*);

/* tb/clock_config_select_test.sv */
/*
 * Self-checking bench for clock_config_select, driving APB and pins.
 * Assumes the checker binds itself; clk_en_i drops only while clock and lock inputs rest.
 */
`timescale 1ns/100ps

module clock_config_select_test
	import clock_config_select_pkg::*;
;
	logic        mclk_i = 1'b0, arst_n_i = 1'b0, clk_en_i = 1'b1;
	logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [3:0]  pstrb_i = 4'hf;
	logic [1:0]  mode_pins_i = 2'b00;
	logic        special_mode_pin_i = 1'b0, pll_locked_i = 1'b1;
	logic        auto_switch_en_i = 1'b0, auto_dynamic_sel_i = 1'b0;
	logic        timing_reference_clock_i = 1'b0, freq_reference_clock_i = 1'b0, pll_clock_i = 1'b0;
	logic [31:0] prdata_o, active_ratio_o, effective_ratio_o, rd;
	logic        pready_o, pslverr_o, primary_clk_o, secondary_out_o, secondary_oe_n_o, ref_div_clk_o, err;
	logic        fractional_source_sel_o, ratio_format_12_20_o, ratio_shift_en_o;
	logic [1:0]  ratio_shift_select_o;
	int          num_errors = 0;
	int          cmp_count = 0;

	always #5 mclk_i = ~mclk_i;

	clock_config_select clock_config_select_inst (.*);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// zero-wait slave, yet the wait is open; only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel_i    <= 1'b1;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (pready_o !== 1'b1);
		rd  = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic set_glb(input logic [2:0] spf, input logic fmt, oou, input logic [1:0] dv, input logic ul);
		apb(1'b1, OFS_GLOBAL, {24'h00_0000, spf, fmt, oou, dv, ul});
	endtask

	task automatic set_mod(input int s, input logic fr, input logic [1:0] hy, ax, sh);
		apb(1'b1, OFS_MODAL_BASE + 8'(4 * s), {25'h000_0000, fr, hy, ax, sh});
	endtask

	function automatic logic [31:0] rv(input int i);
		return {i[7:0] + 8'h10, 24'h00_0ab0};
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, OFS_RATIO_BASE + 8'(4 * i), 32'h0000_0000);
			chk(rd, RATIO_RST);
			apb(1'b1, OFS_RATIO_BASE + 8'(4 * i), rv(i));
			apb(1'b0, OFS_RATIO_BASE + 8'(4 * i), 32'h0000_0000);
			chk(rd, rv(i));
		end
		pstrb_i <= 4'b0001;
		apb(1'b1, OFS_RATIO_BASE, 32'hffff_ffff);
		pstrb_i <= 4'hf;
		apb(1'b0, OFS_RATIO_BASE, 32'h0000_0000);
		chk(rd, rv(0) | 32'h0000_00ff);
		apb(1'b1, OFS_RATIO_BASE, rv(0));
		apb(1'b0, OFS_GLOBAL, 32'h0000_0000);
		chk(rd, {24'h00_0000, GLOBAL_RST});
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(err, 1'b0);
		chk(rd, (32'h0000_0001 << ST_LOCK_BIT) | (32'h0000_0001 << ST_PRI_EN_BIT)
			| (32'h0000_0001 << ST_SEC_EN_BIT) | (32'h0000_0001 << ST_FMT_BIT));
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(err, 1'b1);
		apb(1'b1, OFS_STATUS, 32'h0000_0000);
		chk(err, 1'b1);
	endtask

	task automatic t_ratio;
		for (int f = 0; f < 3; f++) begin
			set_glb(3'b000, f[1], 1'b0, 2'b10, 1'b0);
			for (int s = 0; s < 4; s++)
				set_mod(s, f != 0, 2'(3 - s), 2'b00, 2'b00);
			for (int s = 0; s < 4; s++) begin
				mode_pins_i <= 2'(s);
				tick(3);
				chk(active_ratio_o, (f != 0) ? rv(3 - s) : rv(s));
				chk(fractional_source_sel_o, f != 0);
				chk(ratio_format_12_20_o, f != 1);
			end
		end
		// a low clock enable must freeze the outputs on the old set
		clk_en_i    <= 1'b0;
		mode_pins_i <= 2'b01;
		tick(3);
		chk(active_ratio_o, rv(0));
		clk_en_i    <= 1'b1;
		tick(3);
		chk(active_ratio_o, rv(2));
		mode_pins_i <= 2'b00;
	endtask

	task automatic t_aux;
		set_glb(3'b000, 1'b1, 1'b0, 2'b10, 1'b1);
		for (int c = 0; c < 3; c++) begin
			set_mod(0, 1'b0, 2'b00, 2'(c), 2'b00);
			for (int v = 0; v < 2; v++) begin
				timing_reference_clock_i <= (c == 0) ? v[0] : !v[0];
				freq_reference_clock_i   <= (c == 1) ? v[0] : !v[0];
				pll_clock_i              <= (c == 2) ? v[0] : !v[0];
				tick(3);
				chk(secondary_out_o, v[0]);
				chk(secondary_oe_n_o, 1'b0);
			end
		end
		set_mod(0, 1'b0, 2'b00, 2'b11, 2'b00);
		for (int u = 0; u < 2; u++) begin
			set_glb(3'b000, 1'b1, 1'b0, 2'b10, u[0]);
			for (int l = 0; l < 2; l++) begin
				pll_locked_i <= l[0];
				tick(3);
				chk(secondary_out_o, !u[0] && !l[0]);
				chk(secondary_oe_n_o, u[0] && l[0]);
			end
		end
	endtask

	task automatic t_gate;
		pll_clock_i <= 1'b1;
		for (int o = 0; o < 4; o++) begin
			set_glb(3'b000, 1'b1, o[0], 2'b10, 1'b0);
			pll_locked_i <= o[1];
			tick(3);
			chk(primary_clk_o, o[0] || o[1]);
		end
	endtask

	task automatic t_div;
		int n;
		logic p;
		for (int d = 0; d < 4; d++) begin
			set_glb(3'b000, 1'b1, 1'b0, 2'(d), 1'b0);
			n = 0;
			p = ref_div_clk_o;
			for (int k = 0; k < 36; k++) begin
				timing_reference_clock_i <= k < 32 && k[0];
				@(posedge mclk_i);
				n += int'(ref_div_clk_o && !p);
				p = ref_div_clk_o;
			end
			chk(n, d == 0 ? 4 : d == 1 ? 8 : d == 2 ? 16 : 0);
		end
	endtask

	task automatic t_spf;
		logic hi;
		pll_locked_i <= 1'b1;
		pll_clock_i  <= 1'b1;
		auto_dynamic_sel_i <= 1'b1;
		set_mod(0, 1'b0, 2'b00, 2'b00, 2'b01);
		for (int f = 0; f < 8; f++) begin
			set_glb(3'(f), 1'b1, 1'b0, 2'b10, 1'b0);
			for (int p = 0; p < 2; p++) begin
				hi = p[0];
				special_mode_pin_i       <= hi;
				auto_switch_en_i         <= f == 4;
				timing_reference_clock_i <= f != 7;
				tick(3);
				chk(primary_clk_o, !(hi && (f == 0 || f == 2)));
				chk(secondary_out_o, f == 7 ? hi : !(hi && (f == 1 || f == 2)));
				chk(ratio_shift_en_o, f == 3 && hi);
				chk(ratio_shift_select_o, 2'b01);
				chk(effective_ratio_o, (f == 3 && hi) ? rv(0) >> 2 : rv(0));
				chk(fractional_source_sel_o, f == 4 ? !hi : f == 6 && hi);
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(8);
		arst_n_i <= 1'b1;
		tick(2);
		t_regs;
		t_ratio;
		t_aux;
		t_gate;
		t_div;
		t_spf;
		conclude;
	end

	// all scenarios need well under 5000 cycles
	initial begin
		#200000;
		num_errors++;
		conclude;
	end
endmodule // clock_config_select_test
